// *** design/dos_consts.svh ***
`ifndef DOS_CONSTS_SVH
`define DOS_CONSTS_SVH
// ****************************************************************
// register offsets (byte addresses on the local register port)
// ****************************************************************
`define DOS_OFS_BOARD_CONTROL 8'h00
`define DOS_OFS_CHANNEL_SELECT 8'h04
`define DOS_OFS_SAMPLE_RATE_DIVIDER 8'h08
`define DOS_OFS_BUFFER_CONTROL_STATUS 8'h0C
`define DOS_OFS_OUTPUT_FIFO_PORT 8'h10
`define DOS_OFS_SYNC_CLOCK_DIVIDER 8'h14
// ****************************************************************
// board_control field positions
// ****************************************************************
`define DOS_BC_OUT_EN 0
`define DOS_BC_BURST_MODE 1
`define DOS_BC_SW_TRIG 2
`define DOS_BC_SEQUENTIAL 3
`define DOS_BC_TWOS_COMP 4
`define DOS_BC_CLK_SRC_LO 5
`define DOS_BC_CLK_SRC_HI 6
`define DOS_BC_SW_CLOCK 7
`define DOS_BC_AUTOCAL 8
`define DOS_BC_INIT 9
`define DOS_BC_IRQ_SEL_LO 10
`define DOS_BC_IRQ_SEL_HI 12
`define DOS_BC_CLKIO_OUT 13
`define DOS_BC_SYNC_EN 14
`define DOS_BC_DMA_EN 15
// ****************************************************************
// buffer_control_status field positions
// ****************************************************************
`define DOS_BS_SIZE_LO 0
`define DOS_BS_SIZE_HI 3
`define DOS_BS_CIRCULAR 4
`define DOS_BS_CLEAR 5
`define DOS_BS_EMPTY 8
`define DOS_BS_FULL 9
`define DOS_BS_PARTIAL 10
`define DOS_FIFO_EOF_BIT 16
// ****************************************************************
// reset values and codes
// ****************************************************************
`define DOS_RST_BOARD_CONTROL 16'h0000
`define DOS_RST_CHANNEL_SELECT 16'h0FFF
`define DOS_RST_SAMPLE_RATE_DIVIDER 16'h0031
`define DOS_RST_BUFFER_SIZE 4'hF
`define DOS_RST_SYNC_DIVIDER 16'h0000
`define DOS_MIDRANGE_CODE 16'h8000
`define DOS_MIN_SIZE_LOG2 4'h2
// ****************************************************************
// timing
// ****************************************************************
`define DOS_CORE_CLK_HZ 20000000
`define DOS_AUTOCAL_TIME_MS 3000
`define DOS_AUTOCAL_CYCLES ((`DOS_AUTOCAL_TIME_MS / 1000) * `DOS_CORE_CLK_HZ)
`endif

// *** design/dos_pkg.sv ***
package dos_pkg;
  // ****************************************************************
  // sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_INIT = 5'b00001, // loading correction values into the cal converters
    ST_MID = 5'b00010, // parking every output at midrange
    ST_IDLE = 5'b00100, // waiting for a sample clock
    ST_LOAD = 5'b01000, // walking the channels for one update
    ST_CAL = 5'b10000 // autocalibration running
  } dos_state_t;
  // sample clock sources
  typedef enum logic [1:0] {
    CLK_INTERNAL = 2'h0,
    CLK_EXTERNAL = 2'h1,
    CLK_SOFTWARE = 2'h2
  } dos_clk_src_t;
endpackage

// *** design/dos_rate_div.sv ***
`timescale 1ns/1ns
// ****************************************************************
// programmable divider: one-cycle tick every div+1 enabled cycles
// ****************************************************************
module dos_rate_div #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] count_r; // cycles since the last tick
  // count up and restart on each tick
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (!en) begin
      count_r <= '0;
    end else if (count_r >= div) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + 1'b1;
    end
  end
  assign tick = en && (count_r >= div);
endmodule // dos_rate_div

// *** design/dos_dac_output_sequencer.sv ***
`timescale 1ns/1ns
`include "dos_consts.svh"
module dos_dac_output_sequencer
  import dos_pkg::*;
#(
  parameter int NCH = 12, // output channels
  parameter int AW = 15, // log2 of fitted buffer capacity
  parameter int NCAL = 24, // correction values per init
  parameter int CAL_CYCLES = `DOS_AUTOCAL_CYCLES // autocalibration length
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic regSel,
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regAck,
  input wire logic dmaValid,
  input wire logic [31:0] dmaData,
  output logic dmaReq,
  output logic irq,
  input wire logic burst_trigger_in,
  output logic burst_trigger_out,
  input wire logic extClkIn,
  input wire logic clkIoIn,
  output logic clkIoOut,
  output logic clkIoOe,
  output logic [NCH-1:0][15:0] dacData,
  output logic [NCH-1:0] dacLoad,
  output logic [7:0] nvmAddr,
  input wire logic [15:0] nvmRdata,
  output logic calDacWe,
  output logic [7:0] calDacAddr,
  output logic [15:0] calDacData,
  output logic calActive
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] boardCtl_r; // board_control storage
  logic [15:0] chanSel_r; // channel_select storage
  logic [15:0] rateDiv_r; // sample_rate_divider storage
  logic [15:0] syncDiv_r; // sync clock half-period divider
  logic [3:0] bufSize_r; // log2 active buffer size
  logic bufCirc_r; // circular buffer mode
  logic swTrigPulse; // software trigger write strobe
  logic swClkPulse; // software sample clock write strobe
  logic calStartPulse; // autocal start write strobe
  logic initPulse; // init request write strobe
  logic bufClrPulse; // buffer clear write strobe
  logic wrBoard; // write to board_control
  logic wrFifo; // write to the fifo port
  dos_state_t state_r; // sequencer state
  logic [AW:0] count_r; // entries held
  logic [AW-1:0] wrPtr_r; // fifo write index
  logic [AW-1:0] rdPtr_r; // fifo read index
  logic [16:0] mem [0:(1<<AW)-1]; // fifo storage
  logic [AW:0] capacity; // active buffer size in entries
  logic fifoEmpty; // nothing to output
  logic fifoFull; // active size reached
  logic pop; // sequencer takes the head entry
  logic hostPush; // a host or dma value enters the fifo
  logic [16:0] pushData; // entry being pushed
  logic [16:0] head; // entry at the read index
  assign wrBoard = regSel && regWr && (regAddr == `DOS_OFS_BOARD_CONTROL);
  assign wrFifo = regSel && regWr && (regAddr == `DOS_OFS_OUTPUT_FIFO_PORT);
  assign swTrigPulse = wrBoard && regWdata[`DOS_BC_SW_TRIG];
  assign swClkPulse = wrBoard && regWdata[`DOS_BC_SW_CLOCK];
  assign calStartPulse = wrBoard && regWdata[`DOS_BC_AUTOCAL];
  assign initPulse = wrBoard && regWdata[`DOS_BC_INIT];
  assign bufClrPulse = regSel && regWr && (regAddr == `DOS_OFS_BUFFER_CONTROL_STATUS) &&
    regWdata[`DOS_BS_CLEAR];
  // control registers, 16 bits each except the five buffer control bits; strobe bits are not stored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boardCtl_r <= `DOS_RST_BOARD_CONTROL;
      chanSel_r <= `DOS_RST_CHANNEL_SELECT;
      rateDiv_r <= `DOS_RST_SAMPLE_RATE_DIVIDER;
      syncDiv_r <= `DOS_RST_SYNC_DIVIDER;
      // reset size is the fitted capacity, never beyond the storage
      bufSize_r <= (`DOS_RST_BUFFER_SIZE > 4'(AW)) ? 4'(AW) : `DOS_RST_BUFFER_SIZE;
      bufCirc_r <= 1'b0;
    end else if (regSel && regWr) begin
      case (regAddr)
        `DOS_OFS_BOARD_CONTROL: begin
          boardCtl_r <= regWdata[15:0] & 16'hFC7B;
        end
        `DOS_OFS_CHANNEL_SELECT: begin
          chanSel_r <= regWdata[15:0] & 16'(((1 << NCH) - 1));
        end
        `DOS_OFS_SAMPLE_RATE_DIVIDER: begin
          rateDiv_r <= regWdata[15:0];
        end
        `DOS_OFS_SYNC_CLOCK_DIVIDER: begin
          syncDiv_r <= regWdata[15:0];
        end
        `DOS_OFS_BUFFER_CONTROL_STATUS: begin
          // clamp the size field into four .. fitted capacity
          if (regWdata[3:0] < `DOS_MIN_SIZE_LOG2) begin
            bufSize_r <= `DOS_MIN_SIZE_LOG2;
          end else if (regWdata[3:0] > 4'(AW)) begin
            bufSize_r <= 4'(AW);
          end else begin
            bufSize_r <= regWdata[3:0];
          end
          bufCirc_r <= regWdata[`DOS_BS_CIRCULAR];
        end
        default: begin
          // other offsets store nothing
        end
      endcase
    end
  end
  // ****************************************************************
  // output fifo
  // ****************************************************************
  assign capacity = (AW+1)'(1) << bufSize_r;
  assign fifoEmpty = (count_r == '0);
  assign fifoFull = (count_r >= capacity);
  assign head = mem[rdPtr_r];
  // the dma master fetches only while there is room for a value
  assign dmaReq = boardCtl_r[`DOS_BC_DMA_EN] && !fifoFull;
  // host writes win over dma in the same cycle; circular replay blocks both
  assign hostPush = (wrFifo || (dmaReq && dmaValid)) && !fifoFull &&
    !(pop && bufCirc_r);
  assign pushData = wrFifo ? regWdata[16:0] : dmaData[16:0];
  // pointers and fill level; circular replay pushes the head back
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else if (bufClrPulse) begin
      count_r <= '0;
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else if (pop && bufCirc_r) begin
      wrPtr_r <= wrPtr_r + 1'b1;
      rdPtr_r <= rdPtr_r + 1'b1;
    end else begin
      if (hostPush) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(hostPush) - (AW+1)'(pop);
    end
  end
  // storage write, 17 bits with the end-of-frame mark
  always_ff @(posedge core_clk) begin
    if (pop && bufCirc_r) begin
      mem[wrPtr_r] <= head;
    end else if (hostPush) begin
      mem[wrPtr_r] <= pushData;
    end
  end
  // ****************************************************************
  // clocks, triggers and pin synchronisers
  // ****************************************************************
  logic [2:0] trigSync_r; // burst trigger synchroniser and edge stage
  logic [1:0] extPin_r; // external clock pin synchroniser
  logic [1:0] ioPin_r; // clock pin pair synchroniser
  logic extPrev_r; // edge stage of the chosen external clock
  logic extEdge; // rising edge of the chosen external clock
  logic trigEdge; // rising edge of the burst trigger input
  logic rateTick; // internal generator tick
  logic syncTick; // sync clock half-period tick
  logic sampleTick; // selected sample clock
  logic syncClk_r; // sync clock output level
  logic extRaw; // external clock from the pin chosen
  // pins are synchronised first, the choice is made on clean signals
  assign extRaw = boardCtl_r[`DOS_BC_CLKIO_OUT] ? extPin_r[1] : ioPin_r[1];
  // two flops, then an edge stage that reads only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trigSync_r <= 3'h0;
      extPin_r <= 2'h0;
      ioPin_r <= 2'h0;
      extPrev_r <= 1'b0;
    end else begin
      trigSync_r <= {trigSync_r[1:0], burst_trigger_in};
      extPin_r <= {extPin_r[0], extClkIn};
      ioPin_r <= {ioPin_r[0], clkIoIn};
      extPrev_r <= extRaw;
    end
  end
  assign trigEdge = trigSync_r[1] && !trigSync_r[2];
  assign extEdge = extRaw && !extPrev_r;
  // both generators run off core_clk so each period is a whole number of core_clk cycles
  dos_rate_div #(.W(16)) uRate (
    .core_clk(core_clk),
    .rst(rst),
    .en(boardCtl_r[`DOS_BC_OUT_EN]),
    .div(rateDiv_r),
    .tick(rateTick)
  );
  dos_rate_div #(.W(16)) uSync (
    .core_clk(core_clk),
    .rst(rst),
    .en(boardCtl_r[`DOS_BC_SYNC_EN]),
    .div(syncDiv_r),
    .tick(syncTick)
  );
  // sync clock toggles each half period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syncClk_r <= 1'b0;
    end else if (!boardCtl_r[`DOS_BC_SYNC_EN]) begin
      syncClk_r <= 1'b0;
    end else if (syncTick) begin
      syncClk_r <= !syncClk_r;
    end
  end
  assign clkIoOut = syncClk_r;
  assign clkIoOe = boardCtl_r[`DOS_BC_CLKIO_OUT];
  // sample clock selection
  always_comb begin
    case (dos_clk_src_t'(boardCtl_r[`DOS_BC_CLK_SRC_HI:`DOS_BC_CLK_SRC_LO]))
      CLK_INTERNAL: sampleTick = rateTick;
      CLK_EXTERNAL: sampleTick = extEdge;
      CLK_SOFTWARE: sampleTick = swClkPulse;
      default: sampleTick = 1'b0;
    endcase
  end
  // ****************************************************************
  // burst control
  // ****************************************************************
  logic burstArm_r; // burst running until end of frame
  logic eofSeen_r; // end-of-frame left the buffer this update
  logic trigger; // either trigger source fired
  logic running; // output updates allowed
  assign trigger = swTrigPulse || trigEdge;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      burstArm_r <= 1'b0;
      burst_trigger_out <= 1'b0;
    end else begin
      burst_trigger_out <= trigger && boardCtl_r[`DOS_BC_BURST_MODE];
      if (trigger) begin
        burstArm_r <= 1'b1;
      end else if (eofSeen_r && state_r == ST_IDLE) begin
        burstArm_r <= 1'b0;
      end
    end
  end
  assign running = boardCtl_r[`DOS_BC_OUT_EN] &&
    (!boardCtl_r[`DOS_BC_BURST_MODE] || burstArm_r);
  // ****************************************************************
  // sequencer
  // ****************************************************************
  logic [7:0] step_r; // channel index or cal index
  logic [7:0] walk_r; // channels visited this update
  logic [7:0] seqCh_r; // next channel in sequential mode
  logic [25:0] calCnt_r; // autocalibration cycle count
  logic chanTake; // current walked channel takes a value
  logic walkEnd; // last channel of the walk
  logic [15:0] sample; // head converted to offset binary
  logic pendInit_r; // init requested, held until ST_INIT takes it
  assign chanTake = (state_r == ST_LOAD) && chanSel_r[step_r[3:0]] && !fifoEmpty;
  assign walkEnd = (walk_r == 8'(NCH - 1));
  assign pop = chanTake;
  // twos complement is flipped to offset binary at the converter
  assign sample = boardCtl_r[`DOS_BC_TWOS_COMP] ? {!head[15], head[14:0]} :
    head[15:0];
  assign calActive = (state_r == ST_CAL);
  assign nvmAddr = step_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_INIT;
      step_r <= 8'h00;
      walk_r <= 8'h00;
      seqCh_r <= 8'h00;
      calCnt_r <= 26'h0000000;
      eofSeen_r <= 1'b0;
      pendInit_r <= 1'b0;
      dacData <= '0;
      dacLoad <= '0;
      calDacWe <= 1'b0;
      calDacAddr <= 8'h00;
      calDacData <= 16'h0000;
    end else begin
      dacLoad <= '0;
      calDacWe <= 1'b0;
      if (initPulse) begin
        pendInit_r <= 1'b1;
      end
      case (state_r)
        ST_INIT: begin
          // copy one stored correction value per cycle
          calDacWe <= 1'b1;
          calDacAddr <= step_r;
          calDacData <= nvmRdata;
          // a new request in the same cycle is kept
          if (!initPulse) begin
            pendInit_r <= 1'b0;
          end
          if (step_r == 8'(NCAL - 1)) begin
            step_r <= 8'h00;
            state_r <= ST_MID;
          end else begin
            step_r <= step_r + 1'b1;
          end
        end
        ST_MID: begin
          for (int i = 0; i < NCH; i++) begin
            dacData[i] <= `DOS_MIDRANGE_CODE;
          end
          dacLoad <= '1;
          state_r <= ST_IDLE;
        end
        ST_IDLE: begin
          eofSeen_r <= 1'b0;
          if (pendInit_r) begin
            state_r <= ST_INIT;
          end else if (calStartPulse) begin
            calCnt_r <= 26'h0000000;
            state_r <= ST_CAL;
          end else if (sampleTick && running) begin
            step_r <= boardCtl_r[`DOS_BC_SEQUENTIAL] ? seqCh_r : 8'h00;
            walk_r <= 8'h00;
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (chanTake) begin
            dacData[step_r[3:0]] <= sample;
            if (head[`DOS_FIFO_EOF_BIT]) begin
              eofSeen_r <= 1'b1;
            end
          end
          if (boardCtl_r[`DOS_BC_SEQUENTIAL] && chanTake) begin
            // one channel per clock, updated at once
            dacLoad[step_r[3:0]] <= 1'b1;
            seqCh_r <= (step_r == 8'(NCH - 1)) ? 8'h00 : step_r + 1'b1;
            state_r <= ST_IDLE;
          end else if (walkEnd) begin
            if (!boardCtl_r[`DOS_BC_SEQUENTIAL]) begin
              dacLoad <= NCH'(chanSel_r);
            end
            state_r <= ST_IDLE;
          end else begin
            step_r <= (step_r == 8'(NCH - 1)) ? 8'h00 : step_r + 1'b1;
            walk_r <= walk_r + 1'b1;
          end
        end
        ST_CAL: begin
          if (calCnt_r == 26'(CAL_CYCLES - 1)) begin
            state_r <= ST_INIT;
          end else begin
            calCnt_r <= calCnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= ST_INIT;
        end
      endcase
    end
  end
  // ****************************************************************
  // interrupt condition select
  // ****************************************************************
  always_comb begin
    case (boardCtl_r[`DOS_BC_IRQ_SEL_HI:`DOS_BC_IRQ_SEL_LO])
      3'h1: irq = fifoEmpty;
      3'h2: irq = !fifoFull;
      3'h3: irq = (state_r == ST_IDLE) && !burstArm_r;
      3'h4: irq = (state_r == ST_IDLE) && !pendInit_r;
      default: irq = 1'b0;
    endcase
  end
  // ****************************************************************
  // register read port
  // ****************************************************************
  logic [15:0] bufStatus; // buffer_control_status read value
  logic [15:0] boardRead; // board_control read value
  assign bufStatus = {5'h00, !fifoEmpty && !fifoFull, fifoFull, fifoEmpty, 3'h0,
    bufCirc_r, bufSize_r};
  assign boardRead = boardCtl_r | {6'h00, pendInit_r || (state_r == ST_INIT),
    calActive, 8'h00};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h00000000;
      regAck <= 1'b0;
    end else begin
      regAck <= regSel;
      // read data stands until the next read
      if (regSel && !regWr) begin
        case (regAddr)
          `DOS_OFS_BOARD_CONTROL: regRdata <= {16'h0000, boardRead};
          `DOS_OFS_CHANNEL_SELECT: regRdata <= {16'h0000, chanSel_r};
          `DOS_OFS_SAMPLE_RATE_DIVIDER: regRdata <= {16'h0000, rateDiv_r};
          `DOS_OFS_BUFFER_CONTROL_STATUS: regRdata <= {16'h0000, bufStatus};
          `DOS_OFS_SYNC_CLOCK_DIVIDER: regRdata <= {16'h0000, syncDiv_r};
          default: regRdata <= 32'h00000000;
        endcase
      end
    end
  end
  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_fullWrite;
    wrFifo && fifoFull && !pop;
  endsequence
  a_full_write_ignored: assert property (@(posedge core_clk) disable iff (rst)
    s_fullWrite |=> $stable(wrPtr_r))
    else $error("write accepted while full");
  a_mid_after_init: assert property (@(posedge core_clk) disable iff (rst)
    state_r == ST_MID |=> dacLoad == '1 && dacData[0] == 16'h8000)
    else $error("outputs not parked at midrange");
  a_cal_walk_len: assert property (@(posedge core_clk) disable iff (rst)
    $rose(state_r == ST_INIT) |=> calDacWe [*8])
    else $error("correction load stalled");
  a_count_in_cap: assert property (@(posedge core_clk) disable iff (rst)
    count_r > $past(count_r) |-> count_r <= capacity || $past(bufSize_r) != bufSize_r)
    else $error("fill above active size");
  a_circ_keeps_count: assert property (@(posedge core_clk) disable iff (rst)
    pop && bufCirc_r && !bufClrPulse |=> $stable(count_r))
    else $error("circular replay lost a value");
  a_twos_convert: assert property (@(posedge core_clk) disable iff (rst)
    chanTake && boardCtl_r[`DOS_BC_TWOS_COMP] |=>
      dacData[$past(step_r[3:0])][15] != $past(head[15]))
    else $error("format conversion missing");
  a_inactive_no_pop: assert property (@(posedge core_clk) disable iff (rst)
    state_r == ST_LOAD && !chanSel_r[step_r[3:0]] |-> !pop)
    else $error("inactive channel consumed a value");
  a_seq_one_load: assert property (@(posedge core_clk) disable iff (rst)
    chanTake && boardCtl_r[`DOS_BC_SEQUENTIAL] |=> $onehot(dacLoad))
    else $error("sequential update not single channel");
  a_clkio_dir: assert property (@(posedge core_clk) disable iff (rst)
    clkIoOe == boardCtl_r[`DOS_BC_CLKIO_OUT])
    else $error("clock pin direction wrong");
endmodule // dos_dac_output_sequencer

// *** bench/dos_nvm_model.sv ***
`timescale 1ns/1ns
// ****************************************************************
// correction store: combinational read, value tied to its address
// ****************************************************************
module dos_nvm_model (
  input wire logic [7:0] nvmAddr,
  output logic [15:0] nvmRdata
);
  // upper byte marks the store so a wrong source shows up at once
  assign nvmRdata = {8'hA5, nvmAddr};
endmodule // dos_nvm_model

// *** bench/tb.sv ***
`timescale 1ns/1ns
`include "dos_consts.svh"
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin nErrors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
// ****************************************************************
// bench top: register tasks and scenario sequence
// ****************************************************************
module tb;
  import dos_pkg::*;
  logic core_clk = 0, rst = 1, regSel = 0, regWr = 0, zero = 0;
  logic [7:0] regAddr = 8'h00, nvmAddr, calDacAddr;
  logic [31:0] regWdata = 32'h0, rd, regRdata;
  logic regAck, dmaReq, irq, trigOut, clkIoOut, clkIoOe, calDacWe, calActive;
  logic [11:0][15:0] dacData;
  logic [11:0] dacLoad;
  logic [15:0] nvmRdata, calDacData;
  int nErrors = 0, cmpCount = 0;
  // short counts so the run stays brief
  dos_dac_output_sequencer #(.AW(4), .CAL_CYCLES(20)) dos_dac_output_sequencer_i (
    .core_clk(core_clk), .rst(rst), .regSel(regSel), .regWr(regWr),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
    .dmaValid(zero), .dmaData({31'h0, zero}), .dmaReq(dmaReq), .irq(irq),
    .burst_trigger_in(zero), .burst_trigger_out(trigOut), .extClkIn(zero),
    .clkIoIn(zero), .clkIoOut(clkIoOut), .clkIoOe(clkIoOe), .dacData(dacData),
    .dacLoad(dacLoad), .nvmAddr(nvmAddr), .nvmRdata(nvmRdata), .calDacWe(calDacWe),
    .calDacAddr(calDacAddr), .calDacData(calDacData), .calActive(calActive));
  dos_nvm_model dos_nvm_model_i (.nvmAddr(nvmAddr), .nvmRdata(nvmRdata));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // verdict and end of run
  task automatic closeOut;
    if (nErrors == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one register access; ack and read data stand the cycle after the strobe
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    regSel = 1;
    regWr = wr;
    regAddr = a;
    regWdata = d;
    @(posedge core_clk);
    #1 regSel = 0;
    rd = regRdata;
    `CHK(regAck, 1'b1)
    @(posedge core_clk);
    #1;
  endtask
  // bounded wait for a converter load pattern
  task automatic waitLoad(input logic [11:0] m);
    int i;
    for (i = 0; i < 400 && dacLoad !== m; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 400) begin
      nErrors++;
      closeOut();
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst = 0;
    `CHK(dmaReq, 1'b0)
    `CHK(irq, 1'b0)
    for (int i = 0; i < 10 && calDacWe !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK(calDacWe, 1'b1)
    if (calDacWe !== 1'b1) closeOut();
    `CHK(calDacData, {8'hA5, calDacAddr})
    waitLoad(12'hFFF);
    `CHK(dacData[5], `DOS_MIDRANGE_CODE)
    access(0, `DOS_OFS_CHANNEL_SELECT, 0);
    `CHK(rd[15:0], `DOS_RST_CHANNEL_SELECT)
    access(0, `DOS_OFS_SAMPLE_RATE_DIVIDER, 0);
    `CHK(rd, {16'h0, `DOS_RST_SAMPLE_RATE_DIVIDER})
    access(0, 8'h20, 32'hFFFF);
    `CHK(rd, 32'h0)
    // smallest buffer, then one push more than it holds
    access(1, `DOS_OFS_BUFFER_CONTROL_STATUS, 32'h2);
    for (int k = 0; k < 5; k++) access(1, `DOS_OFS_OUTPUT_FIFO_PORT, 32'hFFFE0000 + k);
    access(0, `DOS_OFS_BUFFER_CONTROL_STATUS, 0);
    `CHK(rd[10:8], 3'b010)
    access(1, `DOS_OFS_CHANNEL_SELECT, 32'h1);
    access(1, `DOS_OFS_BOARD_CONTROL, 32'h1);
    // four stored values in order, then the last one is held
    for (int k = 0; k < 5; k++) begin
      waitLoad(12'h001);
      `CHK(dacData[0], 16'(k < 4 ? k : 3))
      @(posedge core_clk);
      #1;
    end
    access(0, `DOS_OFS_BUFFER_CONTROL_STATUS, 0);
    `CHK(rd[10:8], 3'b001)
    access(1, `DOS_OFS_BOARD_CONTROL, 32'h100);
    `CHK(calActive, 1'b1)
    waitLoad(12'hFFF);
    `CHK(dacData[0], `DOS_MIDRANGE_CODE)
    // circular, twos complement, sequential, software clocked
    access(1, `DOS_OFS_BUFFER_CONTROL_STATUS, 32'h32);
    access(1, `DOS_OFS_OUTPUT_FIFO_PORT, 32'h0001);
    access(1, `DOS_OFS_OUTPUT_FIFO_PORT, 32'hFFFE);
    access(1, `DOS_OFS_CHANNEL_SELECT, 32'h3);
    access(1, `DOS_OFS_BOARD_CONTROL, 32'h2059);
    `CHK(clkIoOe, 1'b1)
    access(1, `DOS_OFS_BOARD_CONTROL, 32'h20D9);
    waitLoad(12'h001);
    `CHK(dacData[0], 16'h8001)
    access(1, `DOS_OFS_BOARD_CONTROL, 32'h20D9);
    waitLoad(12'h002);
    `CHK(dacData[1], 16'h7FFE)
    access(1, `DOS_OFS_BOARD_CONTROL, 32'h20D9);
    waitLoad(12'h001);
    `CHK(dacData[0], 16'h8001)
    access(0, `DOS_OFS_BUFFER_CONTROL_STATUS, 0);
    `CHK(rd[10:8], 3'b100)
    closeOut();
  end
endmodule // tb
